// ---- design/lio_cfg.svh ----
`ifndef LIO_CFG_SVH
`define LIO_CFG_SVH
`define LIO_NSIG          32
`define LIO_PULSE_US      5000
`define LIO_CLK_MHZ       125
`define LIO_PULSE_CYC     (`LIO_PULSE_US * `LIO_CLK_MHZ)
`define LIO_US_CYC        125
`define LIO_OFF_MODE      12'h000
`define LIO_OFF_SET       12'h004
`define LIO_OFF_CLR       12'h008
`define LIO_OFF_IN_STAT   12'h00c
`define LIO_OFF_OUT_STAT  12'h010
`define LIO_OFF_ON_EN_I   12'h014
`define LIO_OFF_OFF_EN_I  12'h018
`define LIO_OFF_ON_EN_O   12'h01c
`define LIO_OFF_OFF_EN_O  12'h020
`define LIO_OFF_EVT_STAT  12'h024
`define LIO_OFF_EVT_MASK  12'h028
`define LIO_OFF_EVT_DATA  12'h02c
`define LIO_OFF_EVT_TIME  12'h030
`define LIO_OFF_TIME      12'h034
`define LIO_OFF_LBL_BASE  12'h100
`define LIO_OFF_LBL_END   12'h1fc
`define LIO_EVT_NEW       0
`define LIO_EVT_LOST      1
`endif

// ---- design/lio_pkg.sv ----
`default_nettype none
package lio_pkg;
    typedef logic [31:0] lio_word_t;
    typedef logic [4:0]  lio_idx_t;
    typedef enum logic [1:0] {
        LIO_EV_IN_OFF  = 2'h0,
        LIO_EV_IN_ON   = 2'h1,
        LIO_EV_OUT_OFF = 2'h2,
        LIO_EV_OUT_ON  = 2'h3
    } lio_evk_e;
endpackage
`default_nettype wire

// ---- design/lio_pulse_cell.sv ----
`include "lio_cfg.svh"
`default_nettype none
module lio_pulse_cell
    import lio_pkg::*;
(
    input  wire logic CLK,
    input  wire logic RSTN,
    input  wire logic set_i,
    input  wire logic clr_i,
    input  wire logic pulse_mode_i,
    output logic      state_o
);
    localparam logic [19:0] PULSE_CYC = 20'(`LIO_PULSE_CYC);
    logic        st_q, st_d;
    logic [19:0] cnt_q, cnt_d;

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        if (set_i) begin
            st_d  = 1'b1;
            cnt_d = PULSE_CYC;
        end else if (clr_i) begin
            st_d  = 1'b0;
            cnt_d = '0;
        end else if (pulse_mode_i && st_q) begin
            cnt_d = cnt_q - 20'h00001;
            if (cnt_q <= 20'h00001)
                st_d = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_q  <= 1'b0;
            cnt_q <= '0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
        end
    end
    assign state_o = st_q;

    AST_PULSE_ENDS: assert property (@(posedge CLK) disable iff (!RSTN)
        (set_i && pulse_mode_i) ##1 (!set_i && !clr_i && pulse_mode_i)[*8]
        |-> state_o) else $error("pulse ended early");
    AST_CLR_NOW: assert property (@(posedge CLK) disable iff (!RSTN)
        (clr_i && !set_i) |=> !state_o)
        else $error("clear not applied");
    AST_SET_NOW: assert property (@(posedge CLK) disable iff (!RSTN)
        set_i |=> state_o) else $error("set not applied");
    COV_PULSE: cover property (@(posedge CLK) disable iff (!RSTN)
        pulse_mode_i && $fell(state_o) && !$past(clr_i));
endmodule
`default_nettype wire

// ---- design/lio_top.sv ----
`include "lio_cfg.svh"
`default_nettype none
module lio_top
    import lio_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RSTN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [31:0] PANEL_SET,
    input  wire logic [31:0] PANEL_CLR,
    input  wire logic [31:0] USER_LOGIC_OUT,
    output logic      [31:0] LOGICAL_IN,
    output logic      [31:0] LOGICAL_OUT,
    output logic             IRQ
);
    lio_word_t mode_q, mode_d, out_q, out_d, in_prev_q, in_prev_d;
    lio_word_t on_i_q, on_i_d, off_i_q, off_i_d;
    lio_word_t on_o_q, on_o_d, off_o_q, off_o_d;
    lio_word_t time_q, time_d, evtime_q, evtime_d;
    lio_word_t rd_q, rd_d, lbl_rd;
    logic [6:0] us_q, us_d;
    logic [1:0] est_q, est_d, emask_q, emask_d;
    logic [7:0] edat_q, edat_d;
    logic       rdy_q, rdy_d, err_q, err_d, irq_q, irq_d;
    lio_word_t  lbl_q [0:63];
    lio_word_t  sw_set, sw_clr, in_st;
    logic       acc, wr, rd, hit_lbl;
    logic [5:0] lbl_idx;

    function automatic logic [6:0] first_evt(input lio_word_t rise,
                                             input lio_word_t fall);
        logic [6:0] r;
        r = 7'h00;
        for (int i = 31; i >= 0; i--) begin
            if (fall[i]) r = {1'b1, 1'b0, 5'(i)};
            if (rise[i]) r = {1'b1, 1'b1, 5'(i)};
        end
        return r;
    endfunction

    assign acc     = PSEL && PENABLE && !rdy_q;
    assign wr      = acc && PWRITE;
    assign rd      = acc && !PWRITE;
    assign hit_lbl = PADDR >= `LIO_OFF_LBL_BASE
                  && PADDR <= `LIO_OFF_LBL_END;
    assign lbl_idx = PADDR[7:2];
    assign lbl_rd  = lbl_q[lbl_idx];
    assign sw_set  = (wr && PADDR == `LIO_OFF_SET) ? PWDATA : '0;
    assign sw_clr  = (wr && PADDR == `LIO_OFF_CLR) ? PWDATA : '0;

    for (genvar g = 0; g < `LIO_NSIG; g++) begin : g_in
        lio_pulse_cell u_cell (
            .CLK          (CORE_CLK),
            .RSTN         (RSTN),
            .set_i        (PANEL_SET[g] | sw_set[g]),
            .clr_i        (PANEL_CLR[g] | sw_clr[g]),
            .pulse_mode_i (mode_q[g]),
            .state_o      (in_st[g])
        );
    end

    // labels: pure storage, never read by the signal logic
    always_ff @(posedge CORE_CLK) begin
        if (wr && hit_lbl)
            lbl_q[lbl_idx] <= PWDATA;
    end

    // events
    lio_word_t ir, if_, or_, of_;
    logic [6:0] ev_i, ev_o;
    logic       any_i, any_o;
    always_comb begin
        ir    = in_st & ~in_prev_q & on_i_q;
        if_   = ~in_st & in_prev_q & off_i_q;
        or_   = USER_LOGIC_OUT & ~out_q & on_o_q;
        of_   = ~USER_LOGIC_OUT & out_q & off_o_q;
        ev_o  = first_evt(or_, of_);
        ev_i  = first_evt(ir, if_);
        any_o = ev_o[6];
        any_i = ev_i[6];
        in_prev_d = in_st;
        out_d     = USER_LOGIC_OUT;
        us_d   = (us_q == 7'(`LIO_US_CYC - 1)) ? 7'h00 : us_q + 7'h01;
        time_d = (us_q == 7'(`LIO_US_CYC - 1)) ? time_q + 32'h1 : time_q;
        est_d    = est_q;
        edat_d   = edat_q;
        evtime_d = evtime_q;
        if (wr && PADDR == `LIO_OFF_EVT_STAT)
            est_d = est_q & ~PWDATA[1:0];
        if (any_o || any_i) begin
            if (est_q[`LIO_EVT_NEW] && !(wr && PADDR == `LIO_OFF_EVT_STAT
                && PWDATA[`LIO_EVT_NEW]))
                est_d[`LIO_EVT_LOST] = 1'b1;
            else begin
                // group bit 1 = outputs, 0 = inputs
                // valid bit dropped: status NEW already says so
                edat_d   = any_o ? {2'b01, ev_o[5:0]}
                                 : {2'b00, ev_i[5:0]};
                evtime_d = time_q;
            end
            est_d[`LIO_EVT_NEW] = 1'b1;
        end
        // one event per cycle; simultaneous ones beyond the first are lost
        if ((any_o && any_i) || $countones({or_, of_, ir, if_}) > 1)
            est_d[`LIO_EVT_LOST] = 1'b1;
    end

    always_comb begin
        mode_d  = mode_q;
        on_i_d  = on_i_q;
        off_i_d = off_i_q;
        on_o_d  = on_o_q;
        off_o_d = off_o_q;
        emask_d = emask_q;
        rd_d    = rd_q;
        err_d   = 1'b0;
        rdy_d   = acc;
        irq_d   = |(est_d & emask_d);
        if (wr) begin
            unique case (PADDR)
                `LIO_OFF_MODE:     mode_d  = PWDATA;
                `LIO_OFF_ON_EN_I:  on_i_d  = PWDATA;
                `LIO_OFF_OFF_EN_I: off_i_d = PWDATA;
                `LIO_OFF_ON_EN_O:  on_o_d  = PWDATA;
                `LIO_OFF_OFF_EN_O: off_o_d = PWDATA;
                `LIO_OFF_EVT_MASK: emask_d = PWDATA[1:0];
                `LIO_OFF_SET, `LIO_OFF_CLR, `LIO_OFF_EVT_STAT: ;
                default:           err_d   = !hit_lbl;
            endcase
        end
        if (rd) begin
            unique case (PADDR)
                `LIO_OFF_MODE:     rd_d = mode_q;
                `LIO_OFF_IN_STAT:  rd_d = in_st;
                `LIO_OFF_OUT_STAT: rd_d = out_q;
                `LIO_OFF_ON_EN_I:  rd_d = on_i_q;
                `LIO_OFF_OFF_EN_I: rd_d = off_i_q;
                `LIO_OFF_ON_EN_O:  rd_d = on_o_q;
                `LIO_OFF_OFF_EN_O: rd_d = off_o_q;
                `LIO_OFF_EVT_STAT: rd_d = {30'h0, est_q};
                `LIO_OFF_EVT_MASK: rd_d = {30'h0, emask_q};
                `LIO_OFF_EVT_DATA: rd_d = {24'h0, edat_q};
                `LIO_OFF_EVT_TIME: rd_d = evtime_q;
                `LIO_OFF_TIME:     rd_d = time_q;
                default: begin
                    rd_d  = hit_lbl ? lbl_rd : 32'h0;
                    err_d = !hit_lbl;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            mode_q <= '0; out_q <= '0; in_prev_q <= '0;
            on_i_q <= '1; off_i_q <= '1; on_o_q <= '1; off_o_q <= '1;
            time_q <= '0; evtime_q <= '0; rd_q <= '0; us_q <= '0;
            est_q <= '0; emask_q <= '0; edat_q <= '0;
            rdy_q <= 1'b0; err_q <= 1'b0; irq_q <= 1'b0;
            LOGICAL_IN <= '0;
        end else begin
            mode_q <= mode_d; out_q <= out_d; in_prev_q <= in_prev_d;
            on_i_q <= on_i_d; off_i_q <= off_i_d;
            on_o_q <= on_o_d; off_o_q <= off_o_d;
            time_q <= time_d; evtime_q <= evtime_d; rd_q <= rd_d;
            us_q <= us_d; est_q <= est_d; emask_q <= emask_d;
            edat_q <= edat_d;
            rdy_q <= rdy_d; err_q <= err_d; irq_q <= irq_d;
            LOGICAL_IN <= in_st;
        end
    end

    assign PRDATA      = rd_q;
    assign PREADY      = rdy_q;
    assign PSLVERR     = err_q;
    assign LOGICAL_OUT = out_q;
    assign IRQ         = irq_q;

    AST_OUT_FOLLOWS: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        ##1 LOGICAL_OUT == $past(USER_LOGIC_OUT))
        else $error("output not following logic");
    AST_EVT_STAMP: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (any_o || any_i) && !est_q[`LIO_EVT_NEW]
        |=> evtime_q == $past(time_q)) else $error("bad stamp");
    AST_EVT_SETS: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (any_o || any_i) |=> est_q[`LIO_EVT_NEW])
        else $error("event not flagged");
    AST_MASKED_DROP: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (on_o_q == 32'h0 && off_o_q == 32'h0) |-> !any_o)
        else $error("masked event kept");
    AST_IRQ_LVL: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        ##1 IRQ == |($past(est_d) & $past(emask_d)))
        else $error("irq mismatch");
    AST_PREADY_ONE: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        PREADY |=> !PREADY) else $error("pready stuck");
    COV_OUT_EVT: cover property (@(posedge CORE_CLK) any_o);
    COV_IN_EVT:  cover property (@(posedge CORE_CLK) any_i);
    COV_IRQ:     cover property (@(posedge CORE_CLK) $rose(IRQ));
endmodule
`default_nettype wire

// ---- sim/lio_far_model.sv ----
`default_nettype none
module lio_far_model (
    input  wire logic        CLK,
    input  wire logic        RSTN,
    input  wire logic [31:0] lvl,
    input  wire logic [31:0] pset,
    input  wire logic [31:0] pclr,
    input  wire logic        in0,
    output logic      [31:0] USER_LOGIC_OUT,
    output logic      [31:0] PANEL_SET,
    output logic      [31:0] PANEL_CLR
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] hold_q;
    // bit 31 is lvl[31] ORed with input 0 stretched by a falling delay gate
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            hold_q         <= 8'h00;
            USER_LOGIC_OUT <= 32'h0;
            PANEL_SET      <= 32'h0;
            PANEL_CLR      <= 32'h0;
        end else begin
            hold_q <= in0 ? 8'hff : hold_q - {7'h0, |hold_q};
            USER_LOGIC_OUT <= {lvl[31] | in0 | (|hold_q), lvl[30:0]};
            PANEL_SET <= pset;
            PANEL_CLR <= pclr;
        end
    end
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
`include "lio_cfg.svh"
`default_nettype none
module tb;
    import lio_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rstn, psel, pen, pwr, rdy, err, slverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata, lvl, pset, pclr, et;
    logic [31:0] uout, pnl_s, pnl_c, lin, lout;
    logic        irq;
    int          fail_count, check_count, cyc;
    lio_top u_dut (.CORE_CLK(clk), .RSTN(rstn), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(rdy), .PSLVERR(slverr),
        .PANEL_SET(pnl_s), .PANEL_CLR(pnl_c), .USER_LOGIC_OUT(uout),
        .LOGICAL_IN(lin), .LOGICAL_OUT(lout), .IRQ(irq));
    lio_far_model u_far (.CLK(clk), .RSTN(rstn), .lvl(lvl), .pset(pset),
        .pclr(pclr), .in0(lin[0]), .USER_LOGIC_OUT(uout),
        .PANEL_SET(pnl_s), .PANEL_CLR(pnl_c));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // setup after an edge, hold until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // no local limit: only the bench timeout ends a hung wait
        do begin
            @(posedge clk);
        end while (rdy !== 1'b1);
        rdata = prdata;
        err   = slverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdata, e);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic panel(input logic [31:0] s, input logic [31:0] c);
        @(posedge clk);
        pset <= s;
        pclr <= c;
        @(posedge clk);
        pset <= 32'h0;
        pclr <= 32'h0;
        wait_cyc(4);
    endtask
    initial begin
        {rstn, psel, pen, pwr} = 4'h0;
        {paddr, pwdata, lvl, pset, pclr} = '0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        wait_cyc(1);
        chk(lin, 32'h0);
        rd_chk(`LIO_OFF_ON_EN_I, 32'hffffffff);
        wait_cyc(300);
        apb(1'b1, `LIO_OFF_ON_EN_O, 32'h0);
        apb(1'b1, `LIO_OFF_OFF_EN_O, 32'h0);
        apb(1'b1, `LIO_OFF_OFF_EN_I, 32'h0);
        apb(1'b1, `LIO_OFF_EVT_MASK, 32'h1);
        apb(1'b1, `LIO_OFF_SET, 32'h8);
        wait_cyc(3);
        chk(lin, 32'h8);
        chk({31'h0, irq}, 32'h1);
        rd_chk(`LIO_OFF_EVT_DATA, 32'h23);
        apb(1'b0, `LIO_OFF_EVT_TIME, 32'h0);
        et = rdata;
        apb(1'b0, `LIO_OFF_TIME, 32'h0);
        chk({31'h0, et != 0 && et <= rdata}, 32'h1);
        apb(1'b1, `LIO_OFF_EVT_STAT, 32'h3);
        wait_cyc(2);
        chk({31'h0, irq}, 32'h0);
        panel(32'h0, 32'h8);
        rd_chk(`LIO_OFF_IN_STAT, 32'h0);
        rd_chk(`LIO_OFF_EVT_STAT, 32'h0);
        // pulse mode: 5 ms cannot run here, only restart and early clear
        apb(1'b1, `LIO_OFF_MODE, 32'h20);
        panel(32'h20, 32'h0);
        chk(lin, 32'h20);
        wait_cyc(1000);
        apb(1'b1, `LIO_OFF_SET, 32'h20);
        rd_chk(`LIO_OFF_IN_STAT, 32'h20);
        apb(1'b1, `LIO_OFF_CLR, 32'h20);
        rd_chk(`LIO_OFF_IN_STAT, 32'h0);
        lvl <= 32'h0000a5c3;
        wait_cyc(3);
        chk(lout, 32'h0000a5c3);
        rd_chk(`LIO_OFF_OUT_STAT, 32'h0000a5c3);
        // input 0 stretched by the far-side delay gate onto output 31
        apb(1'b1, `LIO_OFF_SET, 32'h1);
        apb(1'b1, `LIO_OFF_CLR, 32'h1);
        wait_cyc(20);
        chk({31'h0, lout[31]}, 32'h1);
        wait_cyc(300);
        chk({31'h0, lout[31]}, 32'h0);
        lvl <= 32'h81000000;
        wait_cyc(3);
        chk(lout, 32'h81000000);
        apb(1'b0, 12'h040, 32'h0);
        chk({err, rdata[30:0]}, 32'h80000000);
        apb(1'b1, 12'h104, 32'h4c424c31);
        rd_chk(12'h104, 32'h4c424c31);
        apb(1'b1, `LIO_OFF_SET, 32'h80);
        wait_cyc(3);
        chk(lin, 32'h80);
        rstn <= 1'b0;
        wait_cyc(2);
        rstn <= 1'b1;
        wait_cyc(2);
        chk(lin, 32'h0);
        rd_chk(`LIO_OFF_IN_STAT, 32'h0);
        test_done();
    end
endmodule
`default_nettype wire
